// file: rtl/dsk_skip_decode.v
/*
 * skip-instruction decoder and executor of the capture dma sequencer.
 * assumes the fetch logic offers dwords with valid/ready and the fifos pop counted lanes.
 */
// Operation
// - opcode 0010 is one dword; drop count bits 11:0 from pixel fifo
// - discard is byte granular, any start or end lane allowed
// - opcode 1010 fetches two dwords, discards across luma and both chroma fifos
// - planar luma discard count is first dword bits 11:0
// - second dword: chroma a count bits 11:0, chroma b bits 27:16
// - first flag marks line start, last flag marks line end
// - early fifo end of line aborts instructions until one with last flag
// - planar discard paces the two chroma fifos together; each drops its own byte count
`timescale 1ns/1ps
`include "dsk_map.vh"
module dsk_skip_decode (
	input  wire        i_clk,
	input  wire        i_reset_n,
	input  wire [31:0] i_instr,
	input  wire        i_instr_valid,
	output reg         o_instr_ready,
	input  wire [2:0]  i_pix_avail,
	input  wire [2:0]  i_luma_avail,
	input  wire [2:0]  i_chra_avail,
	input  wire [2:0]  i_chrb_avail,
	input  wire        i_fifo_eol,
	output reg  [2:0]  o_pix_pop,
	output reg  [2:0]  o_luma_pop,
	output reg  [2:0]  o_chra_pop,
	output reg  [2:0]  o_chrb_pop,
	output reg  [3:0]  o_flags_set,
	output reg  [3:0]  o_flags_clr,
	output reg         o_flags_stb,
	output reg         o_irq,
	output reg         o_done,
	output reg         o_line_first,
	output reg         o_line_last,
	output reg         o_aborting
);
	localparam ST_IDLE  = 4'b0001;
	localparam ST_DW1   = 4'b0010;
	localparam ST_RUN   = 4'b0100;
	localparam ST_FIN   = 4'b1000;

	reg [3:0]  state_r;
	reg [31:0] dw0_r;
	reg        planar_r;
	reg        abort_r;
	reg        load_r;
	reg [11:0] pix_cnt_r;
	reg [11:0] luma_cnt_r;
	reg [11:0] chra_cnt_r;
	reg [11:0] chrb_cnt_r;
	wire [2:0] pix_pop;
	wire [2:0] luma_pop;
	wire [2:0] chra_pop;
	wire [2:0] chrb_pop;
	wire [3:0] busy;
	wire [3:0] op_in;
	wire       take;
	wire       abort_now;
	wire [2:0] chr_avail;

	assign op_in = i_instr[`DSK_OP_HI:`DSK_OP_LO];
	assign take  = i_instr_valid && o_instr_ready;
	// early eol while a skip runs kills it; held until the marked last one finishes
	assign abort_now = abort_r || (i_fifo_eol && (state_r == ST_RUN) && !dw0_r[`DSK_LAST_BIT]);

	// ----------------------------------------------------------------
	// instruction fetch and sequencing
	// ----------------------------------------------------------------
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r       <= ST_IDLE;
			dw0_r         <= 32'h0000_0000;
			planar_r      <= 1'b0;
			abort_r       <= 1'b0;
			load_r        <= 1'b0;
			pix_cnt_r     <= `DSK_CNT_ZERO;
			luma_cnt_r    <= `DSK_CNT_ZERO;
			chra_cnt_r    <= `DSK_CNT_ZERO;
			chrb_cnt_r    <= `DSK_CNT_ZERO;
			o_instr_ready <= 1'b1;
			o_flags_set   <= `DSK_FLAGS_RST;
			o_flags_clr   <= `DSK_FLAGS_RST;
			o_flags_stb   <= 1'b0;
			o_irq         <= 1'b0;
			o_done        <= 1'b0;
			o_line_first  <= 1'b0;
			o_line_last   <= 1'b0;
			o_aborting    <= 1'b0;
		end else begin
			load_r      <= 1'b0;
			o_flags_stb <= 1'b0;
			o_irq       <= 1'b0;
			o_done      <= 1'b0;
			o_aborting  <= abort_now;
			case (state_r)
			ST_IDLE: begin
				if (take && (op_in == `DSK_OP_PACKED_SKIP)) begin
					dw0_r      <= i_instr;
					planar_r   <= 1'b0;
					pix_cnt_r  <= i_instr[`DSK_CNT_A_HI:`DSK_CNT_A_LO];
					luma_cnt_r <= `DSK_CNT_ZERO;
					chra_cnt_r <= `DSK_CNT_ZERO;
					chrb_cnt_r <= `DSK_CNT_ZERO;
					load_r     <= 1'b1;
					o_instr_ready <= 1'b0;
					o_line_first  <= i_instr[`DSK_FIRST_BIT];
					o_line_last   <= i_instr[`DSK_LAST_BIT];
					state_r    <= ST_RUN;
				end else if (take && (op_in == `DSK_OP_PLANAR_SKIP)) begin
					dw0_r      <= i_instr;
					planar_r   <= 1'b1;
					pix_cnt_r  <= `DSK_CNT_ZERO;
					luma_cnt_r <= i_instr[`DSK_CNT_A_HI:`DSK_CNT_A_LO];
					o_line_first <= i_instr[`DSK_FIRST_BIT];
					o_line_last  <= i_instr[`DSK_LAST_BIT];
					state_r    <= ST_DW1;
				end
			end
			ST_DW1: begin
				if (take) begin
					chra_cnt_r <= i_instr[`DSK_CNT_A_HI:`DSK_CNT_A_LO];
					chrb_cnt_r <= i_instr[`DSK_CNT_B_HI:`DSK_CNT_B_LO];
					load_r     <= 1'b1;
					o_instr_ready <= 1'b0;
					state_r    <= ST_RUN;
				end
			end
			ST_RUN: begin
				// latch the early end so the abort outlives this instruction
				if (abort_now) begin
					abort_r <= 1'b1;
				end
				// wait one cycle after load so busy flags are valid
				if (!load_r && (busy == 4'h0 || abort_now)) begin
					state_r <= ST_FIN;
				end
			end
			ST_FIN: begin
				// abort persists across instructions until the marked last one ends
				abort_r <= abort_r && !dw0_r[`DSK_LAST_BIT];
				o_flags_set <= dw0_r[`DSK_STAT_HI:`DSK_STAT_LO+4];
				o_flags_clr <= dw0_r[`DSK_STAT_LO+3:`DSK_STAT_LO];
				o_flags_stb <= 1'b1;
				o_irq       <= dw0_r[`DSK_IRQ_BIT];
				o_done      <= 1'b1;
				o_instr_ready <= 1'b1;
				state_r     <= ST_IDLE;
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// per-fifo lane droppers; chroma pair shares pace, each with its own count
	// ----------------------------------------------------------------
	// packed pixel fifo dropper; idle with a zero count in planar mode
	dsk_lane_drop u_pix (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_load    (load_r),
		.i_count   (pix_cnt_r),
		.i_abort   (abort_now),
		.i_avail   (i_pix_avail),
		.o_pop_cnt (pix_pop),
		.o_busy    (busy[0])
	);

	// luma dropper; idle with a zero count in packed mode
	dsk_lane_drop u_luma (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_load    (load_r),
		.i_count   (luma_cnt_r),
		.i_abort   (abort_now),
		.i_avail   (i_luma_avail),
		.o_pop_cnt (luma_pop),
		.o_busy    (busy[1])
	);

	// both chroma droppers see the smaller availability so they stay in step;
	// trade-off: the faster chroma fifo is held back to the slower one's pace
	assign chr_avail = (i_chra_avail < i_chrb_avail) ? i_chra_avail : i_chrb_avail;

	dsk_lane_drop u_chra (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_load    (load_r),
		.i_count   (chra_cnt_r),
		.i_abort   (abort_now),
		.i_avail   (chr_avail),
		.o_pop_cnt (chra_pop),
		.o_busy    (busy[2])
	);

	dsk_lane_drop u_chrb (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_load    (load_r),
		.i_count   (chrb_cnt_r),
		.i_abort   (abort_now),
		.i_avail   (chr_avail),
		.o_pop_cnt (chrb_pop),
		.o_busy    (busy[3])
	);

	// pops re-registered so every top output is a flop
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pix_pop  <= 3'h0;
			o_luma_pop <= 3'h0;
			o_chra_pop <= 3'h0;
			o_chrb_pop <= 3'h0;
		end else begin
			o_pix_pop  <= pix_pop;
			o_luma_pop <= planar_r ? luma_pop : 3'h0;
			o_chra_pop <= planar_r ? chra_pop : 3'h0;
			o_chrb_pop <= planar_r ? chrb_pop : 3'h0;
		end
	end
endmodule

// file: rtl/dsk_map.vh
/*
 * constants for the skip-instruction decoder: opcodes, field positions, widths.
 * assumes inclusion by its bare name from the decoder files.
 */
`ifndef DSK_MAP_VH
`define DSK_MAP_VH
`define DSK_OP_PACKED_SKIP  4'h2
`define DSK_OP_PLANAR_SKIP  4'ha
`define DSK_OP_HI           31
`define DSK_OP_LO           28
`define DSK_CNT_A_HI        11
`define DSK_CNT_A_LO        0
`define DSK_CNT_B_HI        27
`define DSK_CNT_B_LO        16
`define DSK_STAT_HI         23
`define DSK_STAT_LO         16
`define DSK_IRQ_BIT         24
`define DSK_LAST_BIT        26
`define DSK_FIRST_BIT       27
`define DSK_CNT_W           12
`define DSK_CNT_ZERO        12'h000
`define DSK_FLAGS_RST       4'h0
`endif

// file: rtl/dsk_lane_drop.v
/*
 * one fifo's byte-granular discard counter: drops up to i_avail byte lanes per cycle.
 * assumes the fifo pops the number of lanes asked when o_pop_cnt is nonzero and i_avail covers it.
 */
`timescale 1ns/1ps
`include "dsk_map.vh"
module dsk_lane_drop (
	input  wire        i_clk,
	input  wire        i_reset_n,
	input  wire        i_load,
	input  wire [11:0] i_count,
	input  wire        i_abort,
	input  wire [2:0]  i_avail,
	output reg  [2:0]  o_pop_cnt,
	output reg         o_busy
);
	reg [11:0] left_r;
	reg [11:0] left_nxt;
	reg [2:0]  take;

	// ----------------------------------------------------------------
	// lane take: any start or stop lane, no alignment needed
	// ----------------------------------------------------------------
	always @* begin
		take = 3'h0;
		if (o_busy && !i_abort) begin
			if (left_r > {9'h000, i_avail})
				take = i_avail;
			else
				take = left_r[2:0];
		end
		left_nxt = left_r - {9'h000, take};
	end

	// registered pop so the fifo sees a flop output
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			left_r    <= `DSK_CNT_ZERO;
			o_pop_cnt <= 3'h0;
			o_busy    <= 1'b0;
		end else if (i_load) begin
			left_r    <= i_count;
			o_pop_cnt <= 3'h0;
			o_busy    <= (i_count != `DSK_CNT_ZERO);
		end else begin
			left_r    <= i_abort ? `DSK_CNT_ZERO : left_nxt;
			o_pop_cnt <= take;
			o_busy    <= !i_abort && (left_nxt != `DSK_CNT_ZERO);
		end
	end
endmodule

// file: dv/dsk_fifo_model.sv
/* fifo partner for the pixel, luma and both chroma fifos: offers i_rate bytes each cycle, tallies pops.
   assumes pops never exceed the offered lanes. */
`timescale 1ns/1ps
module dsk_fifo_model (
	input  wire        i_clk,
	input  wire        i_reset_n,
	input  wire [2:0]  i_rate,
	input  wire [2:0]  i_pix, i_luma, i_chra, i_chrb,
	output wire [2:0]  o_avail,
	output reg  [15:0] o_pix_n, o_luma_n, o_chra_n, o_chrb_n,
	output reg         o_over
);
	// same rate on all fifos; rate only changes while idle
	assign o_avail = i_rate;
	// byte tallies; a pop beyond the offer is latched as a fault
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{o_pix_n, o_luma_n, o_chra_n, o_chrb_n} <= 64'h0;
			o_over <= 1'b0;
		end else begin
			o_pix_n <= o_pix_n + i_pix;
			o_luma_n <= o_luma_n + i_luma;
			o_chra_n <= o_chra_n + i_chra;
			o_chrb_n <= o_chrb_n + i_chrb;
			o_over <= o_over | (i_pix > i_rate) | (i_luma > i_rate) | (i_chra > i_rate) | (i_chrb > i_rate);
		end
	end
endmodule

// file: dv/dsk_skip_properties.sv
/* port checker for the skip decoder.
   assumes binding onto dsk_skip_decode. */
`timescale 1ns/1ps
module dsk_skip_props (
	input wire        i_clk, i_reset_n, i_instr_valid, i_fifo_eol,
	input wire [31:0] i_instr,
	input wire        o_instr_ready, o_flags_stb, o_irq, o_done,
	input wire        o_line_first, o_line_last, o_aborting,
	input wire [2:0]  o_pix_pop, o_luma_pop, o_chra_pop, o_chrb_pop
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	wire take = i_instr_valid && o_instr_ready;
	// ----------------------------------------
	// port relations
	// ----------------------------------------
	a_chroma_pair: assert property (o_chra_pop == o_chrb_pop)
		else $error("chroma pops differ");
	a_lane_limit: assert property (o_pix_pop <= 3'h4 && o_luma_pop <= 3'h4)
		else $error("pop above four lanes");
	a_packed_busy: assert property (take && i_instr[31:28] == 4'h2 |=> !o_instr_ready)
		else $error("ready after packed take");
	a_planar_second: assert property (take && i_instr[31:28] == 4'ha |=> o_instr_ready)
		else $error("second dword refused");
	a_done_ready: assert property (o_done |-> o_instr_ready)
		else $error("done without ready");
	a_strobe_done: assert property (o_flags_stb |-> o_done)
		else $error("flag strobe off completion");
	a_irq_done: assert property (o_irq |-> o_done)
		else $error("irq off completion");
	a_quiet_after: assert property (o_done |=> o_pix_pop == 3'h0 && o_luma_pop == 3'h0)
		else $error("pop right after done");
	// two quiet cycles allowed for the flag load
	a_flags_hold: assert property (!take ##1 !take |=> $stable(o_line_first) && $stable(o_line_last))
		else $error("line flags moved");
	a_early_abort: assert property ($rose(i_fifo_eol) && !o_instr_ready && !o_line_last |-> ##[1:4] o_aborting)
		else $error("early end not aborted");
	cover property (o_done && o_irq);
	cover property (o_aborting);
	cover property (o_chra_pop != 3'h0);
endmodule
bind dsk_skip_decode dsk_skip_props dsk_skip_props_i (.*);

// file: dv/testbench.sv
/* self-checking bench for the skip decoder.
   assumes the fifo model as partner, inputs driven on falling edges. */
`timescale 1ns/1ps
module testbench;
	reg         clk = 0, rst_n = 0, valid = 0, line_last_flag = 0;
	reg  [31:0] instr = 32'h0;
	reg  [2:0]  rate = 3'h4;
	wire        rdy, stb, irq, done, lf, ll, abt, over;
	wire [2:0]  av, pp, lp, ap, bp;
	wire [3:0]  fs, fc;
	wire [15:0] np, nl, na, nb;
	integer     err_total = 0, total_checks = 0;
	dsk_skip_decode dsk_skip_decode_i (.i_clk(clk), .i_reset_n(rst_n), .i_instr(instr),
		.i_instr_valid(valid), .o_instr_ready(rdy), .i_pix_avail(av), .i_luma_avail(av),
		.i_chra_avail(av), .i_chrb_avail(av), .i_fifo_eol(line_last_flag), .o_pix_pop(pp), .o_luma_pop(lp),
		.o_chra_pop(ap), .o_chrb_pop(bp), .o_flags_set(fs), .o_flags_clr(fc), .o_flags_stb(stb),
		.o_irq(irq), .o_done(done), .o_line_first(lf), .o_line_last(ll), .o_aborting(abt));
	dsk_fifo_model dsk_fifo_model_i (.i_clk(clk), .i_reset_n(rst_n), .i_rate(rate), .i_pix(pp),
		.i_luma(lp), .i_chra(ap), .i_chrb(bp), .o_avail(av), .o_pix_n(np), .o_luma_n(nl),
		.o_chra_n(na), .o_chrb_n(nb), .o_over(over));
	initial forever #10 clk = ~clk;
	task close_out;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string nm, input [31:0] s, input [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask
	// hold the dword until a falling edge sees ready, so the take edge is known
	task send(input [31:0] d);
		instr = d;
		valid = 1;
		while (rdy !== 1'b1) @(negedge clk);
		@(negedge clk);
	endtask
	task finish_op(input [31:0] w);
		integer n;
		valid = 0;
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("done", done, 1);
		chk("stb", stb, 1);
		chk("set", fs, w[23:20]);
		chk("clr", fc, w[19:16]);
		chk("irq", irq, w[24]);
		@(negedge clk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_packed;
		reg [15:0] b;
		reg [11:0] c;
		rate = 3'h3;
		for (int i = 0; i < 3; i++) begin
			c = (i == 0) ? 12'h005 : (i == 1) ? 12'h000 : 12'hfff;
			b = np;
			send({20'h2fa5f, c});
			finish_op(32'h2fa5_f000);
			chk("pix", np - b, c);
			chk("ends", {lf, ll}, 2'b11);
		end
	endtask
	task t_planar;
		rate = 3'h2;
		send(32'ha83c_0009);
		send(32'h0006_0006);
		finish_op(32'ha83c_0009);
		chk("luma", nl, 9);
		chk("chra", na, 6);
		chk("chrb", nb, 6);
		chk("ends", {lf, ll}, 2'b10);
	endtask
	task t_ignore;
		send(32'h1000_0000);
		valid = 0;
		repeat (4) begin
			@(negedge clk);
			chk("idle", {rdy, done}, 2'b10);
		end
	endtask
	task t_abort;
		rate = 3'h4;
		send(32'h2000_0100);
		valid = 0;
		repeat (6) @(negedge clk);
		line_last_flag = 1;
		repeat (6) @(negedge clk);
		chk("abort", abt, 1);
		line_last_flag = 0;
		send(32'h2400_0004);
		finish_op(32'h2400_0004);
		repeat (2) @(negedge clk);
		chk("abort", abt, 0);
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		t_packed;
		t_planar;
		t_ignore;
		t_abort;
		chk("over", over, 0);
		close_out;
	end
	// watchdog well past the longest expected run
	initial begin
		#300000;
		err_total++;
		close_out;
	end
endmodule
